// >>> ctte_map.svh
// Constants for the conditional transfer and accumulator test executor.
// Assumes one 200 MHz core clock and instruction words presented by the fetch stage.
`ifndef CTTE_MAP_SVH
`define CTTE_MAP_SVH
`define CTTE_OP_COND_SINGLE 8'h02
`define CTTE_OP_COND_PAIR 8'h03
`define CTTE_OP_HI 23
`define CTTE_OP_LO 16
`define CTTE_COND_HI 15
`define CTTE_COND_LO 12
`define CTTE_SEL_HI 6
`define CTTE_SEL_LO 3
`define CTTE_SRCP_HI 10
`define CTTE_SRCP_LO 8
`define CTTE_DSTP_HI 2
`define CTTE_DSTP_LO 0
`define CTTE_ALU_TAG_HI 7
`define CTTE_ALU_TAG_LO 0
`define CTTE_COPY_LOW 3'h1
`define CTTE_TEST_LOW 4'h3
`define CTTE_TEST_MASK_LOW 4'h7
`define CTTE_SIGN_BIT 55
`define CTTE_EXEC_CYCLES 2'h2
`endif

// >>> ctte_pkg.sv
// Types for the conditional transfer and accumulator test executor.
// Assumes the constants header is compiled alongside.
package ctte_pkg;
    // Condition-code flags of the status byte.
    typedef struct packed {
        logic scaling;
        logic limit;
        logic extension;
        logic unnormalized;
        logic negative;
        logic zero;
        logic overflow;
        logic carry;
    } ctte_flags_type;

    // Write-back request towards the register files.
    typedef struct packed {
        logic accWrite;
        logic accDest;
        logic [55:0] accValue;
        logic ptrWrite;
        logic [2:0] ptrDest;
        logic [15:0] ptrValue;
    } ctte_write_type;

    // Condition codes in field order.
    typedef enum logic [3:0] {
        CTTE_CARRY_CLEAR = 4'h0, CTTE_GREATER_EQUAL = 4'h1, CTTE_NOT_EQUAL = 4'h2,
        CTTE_PLUS = 4'h3, CTTE_NOT_NORMALIZED = 4'h4, CTTE_EXTENSION_CLEAR = 4'h5,
        CTTE_LIMIT_CLEAR = 4'h6, CTTE_GREATER_THAN = 4'h7, CTTE_CARRY_SET = 4'h8,
        CTTE_LESS_THAN = 4'h9, CTTE_EQUAL = 4'hA, CTTE_MINUS = 4'hB,
        CTTE_NORMALIZED = 4'hC, CTTE_EXTENSION_SET = 4'hD, CTTE_LIMIT_SET = 4'hE,
        CTTE_LESS_EQUAL = 4'hF
    } ctte_cond_type;
endpackage

// >>> ctte_exec.sv
// Decoder and executor for conditional transfer, register copy and accumulator test.
// Assumes operands and flags are stable while instrValid is high and that the
// parallel-move unit reports its extra cycles and any limiting it performs.
`timescale 1ns/10ps
`include "ctte_map.svh"

module ctte_exec #(
    parameter int ACC_WIDTH = 56,
    parameter int IN_WIDTH = 24,
    parameter int PTR_WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic instrValid,
    input wire logic [23:0] instrWord,
    input wire logic [55:0] accA,
    input wire logic [55:0] accB,
    input wire logic [23:0] inX0,
    input wire logic [23:0] inX1,
    input wire logic [23:0] inY0,
    input wire logic [23:0] inY1,
    input wire logic [15:0] pointerFile [8],
    input wire ctte_pkg::ctte_flags_type flagsIn,
    input wire logic moveLimited,
    input wire logic moveScaling,
    input wire logic [3:0] moveExtraCycles,
    output logic busy,
    output logic done,
    output logic moveEnable,
    output ctte_pkg::ctte_write_type writeBack,
    output logic flagsWrite,
    output ctte_pkg::ctte_flags_type flagsOut
);
    import ctte_pkg::*;

    // Refuse at elaboration any widths that the fixed ports cannot carry.
    if (ACC_WIDTH != 56 || IN_WIDTH != 24 || PTR_WIDTH != 16)
    begin : g_width_check
        $error("ctte_exec supports only 56/24/16 bit datapath widths.");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode.

    // Opcode classification.
    wire [7:0] upperByte = instrWord[`CTTE_OP_HI:`CTTE_OP_LO];
    wire isCondSingle = upperByte == `CTTE_OP_COND_SINGLE;
    wire isCondPair = upperByte == `CTTE_OP_COND_PAIR;
    wire isCond = isCondSingle || isCondPair;
    wire isCopy = !isCond && instrWord[7] == 1'b0 && instrWord[2:0] == `CTTE_COPY_LOW;
    wire isTest = !isCond && instrWord[7] == 1'b0
        && (instrWord[3:0] & `CTTE_TEST_MASK_LOW) == `CTTE_TEST_LOW
        && instrWord[6:4] == 3'h0;
    wire isKnown = isCond || isCopy || isTest;

    // Field extraction.
    wire [3:0] condField = instrWord[`CTTE_COND_HI:`CTTE_COND_LO];
    wire [3:0] selField = instrWord[`CTTE_SEL_HI:`CTTE_SEL_LO];
    wire [2:0] srcPtrSel = instrWord[`CTTE_SRCP_HI:`CTTE_SRCP_LO];
    wire [2:0] dstPtrSel = instrWord[`CTTE_DSTP_HI:`CTTE_DSTP_LO];
    wire testDest = instrWord[3];

    ////////////////////////////////////////////////////////////////////////////
    // Condition evaluation.

    // Signed and normalization terms.
    wire nXorV = flagsIn.negative ^ flagsIn.overflow;
    wire gtTerm = flagsIn.zero | nXorV;
    wire normTerm = flagsIn.zero | (~flagsIn.unnormalized & ~flagsIn.extension);
    logic condTrue;

    // Condition table.
    always_comb
    begin
        unique case (ctte_cond_type'(condField))
            CTTE_CARRY_CLEAR: condTrue = ~flagsIn.carry;
            CTTE_CARRY_SET: condTrue = flagsIn.carry;
            CTTE_EXTENSION_CLEAR: condTrue = ~flagsIn.extension;
            CTTE_EXTENSION_SET: condTrue = flagsIn.extension;
            CTTE_LIMIT_CLEAR: condTrue = ~flagsIn.limit;
            CTTE_LIMIT_SET: condTrue = flagsIn.limit;
            CTTE_EQUAL: condTrue = flagsIn.zero;
            CTTE_NOT_EQUAL: condTrue = ~flagsIn.zero;
            CTTE_MINUS: condTrue = flagsIn.negative;
            CTTE_PLUS: condTrue = ~flagsIn.negative;
            CTTE_GREATER_EQUAL: condTrue = ~nXorV;
            CTTE_LESS_THAN: condTrue = nXorV;
            CTTE_GREATER_THAN: condTrue = ~gtTerm;
            CTTE_LESS_EQUAL: condTrue = gtTerm;
            CTTE_NORMALIZED: condTrue = normTerm;
            CTTE_NOT_NORMALIZED: condTrue = ~normTerm;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source selection.

    // Input registers are placed in the middle portion with sign extension, zero low.
    function automatic logic [55:0] extendInput(input logic [23:0] value);
        extendInput = {{8{value[23]}}, value, 24'h000000};
    endfunction

    logic [55:0] srcValue;

    // Source and accumulator destination decode.
    always_comb
    begin
        srcValue = accB;
        if (selField[3])
        begin
            unique case (selField[2:1])
                2'h0: srcValue = extendInput(inX0);
                2'h1: srcValue = extendInput(inY0);
                2'h2: srcValue = extendInput(inX1);
                2'h3: srcValue = extendInput(inY1);
            endcase
        end
        else if (selField[0])
        begin
            srcValue = accA;
        end
    end

    wire selLegal = selField[3] || selField[2:1] == 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencing.

    typedef enum logic [1:0] {IDLE, EXEC, MOVE_WAIT} ctte_state_type;
    ctte_state_type state;
    ctte_state_type next_state;
    logic [3:0] cycleCount;
    logic [3:0] next_cycleCount;
    logic isCondHeld;
    logic testDestHeld;

    // The first cycle is the accept cycle; the second completes conditional forms and any instruction whose moveExtraCycles is zero.
    wire accept = state == IDLE && instrValid && isKnown;

    always_comb
    begin
        next_state = state;
        next_cycleCount = cycleCount;
        unique case (state)
            IDLE:
                if (accept)
                begin
                    next_state = EXEC;
                    next_cycleCount = isCond ? 4'h0 : moveExtraCycles;
                end
            EXEC:
                if (cycleCount == 4'h0)
                begin
                    next_state = IDLE;
                end
                else
                begin
                    next_state = MOVE_WAIT;
                end
            MOVE_WAIT:
                if (cycleCount == 4'h1)
                begin
                    next_state = IDLE;
                    next_cycleCount = 4'h0;
                end
                else
                begin
                    next_cycleCount = cycleCount - 4'h1;
                end
        endcase
    end

    // State and captured decode.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state <= IDLE;
            cycleCount <= 4'h0;
            isCondHeld <= 1'b0;
            testDestHeld <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cycleCount <= next_cycleCount;
            if (accept)
            begin
                isCondHeld <= isCond;
                testDestHeld <= testDest;
            end
        end
    end

    wire finishing = (state == EXEC && cycleCount == 4'h0)
        || (state == MOVE_WAIT && cycleCount == 4'h1);
    assign busy = state != IDLE;
    assign done = finishing;
    // Parallel moves are granted only alongside copy and test.
    assign moveEnable = busy && !isCondHeld;

    ////////////////////////////////////////////////////////////////////////////
    // Results, registered at accept so a false condition writes nothing.

    wire [55:0] testAcc = testDest ? accB : accA;
    ctte_flags_type moveFlags;
    ctte_flags_type testFlags;
    ctte_flags_type next_flagsOut;

    // Move flags merge sticky limiting and scaling from the parallel move; test flags
    // then subtract zero: negative from sign, zero from value, overflow cleared.
    always_comb
    begin
        moveFlags = flagsIn;
        moveFlags.limit = flagsIn.limit | moveLimited;
        moveFlags.scaling = flagsIn.scaling | moveScaling;
        testFlags = moveFlags;
        testFlags.negative = testAcc[`CTTE_SIGN_BIT];
        testFlags.zero = testAcc == 56'h0;
        testFlags.overflow = 1'b0;
        testFlags.carry = 1'b0;
        testFlags.extension = !(&testAcc[55:47] || ~|testAcc[55:47]);
        testFlags.unnormalized = !(testAcc[47] ^ testAcc[46]);
        next_flagsOut = testFlags;
    end

    wire condWrite = isCond && condTrue && selLegal;
    wire copyWrite = isCopy && selLegal;

    // Write-back and flag output registers.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            writeBack <= '0;
            flagsOut <= '0;
        end
        else if (accept)
        begin
            writeBack.accWrite <= condWrite || copyWrite;
            writeBack.accDest <= selField[0];
            writeBack.accValue <= srcValue;
            writeBack.ptrWrite <= condWrite && isCondPair;
            writeBack.ptrDest <= dstPtrSel;
            writeBack.ptrValue <= pointerFile[srcPtrSel];
            flagsOut <= isTest ? next_flagsOut : (isCopy ? moveFlags : flagsIn);
        end
        else if (finishing)
        begin
            writeBack.accWrite <= 1'b0;
            writeBack.ptrWrite <= 1'b0;
        end
    end

    // Flags change only at completion; conditional forms never write them.
    assign flagsWrite = finishing && !isCondHeld;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    property p_cond_flags;
        @(posedge clk) disable iff (!rst_n)
        accept && isCond |=> !flagsWrite && flagsOut == $past(flagsIn);
    endproperty
    a_cond_flags: assert property (p_cond_flags)
        else $error("Flags written by conditional form.");

    property p_cond_two;
        @(posedge clk) disable iff (!rst_n)
        accept && isCond |=> finishing ##1 state == IDLE;
    endproperty
    a_cond_two: assert property (p_cond_two)
        else $error("Conditional form not two cycles.");

    property p_false_nowrite;
        @(posedge clk) disable iff (!rst_n)
        accept && isCond && !condTrue |=> !writeBack.accWrite && !writeBack.ptrWrite;
    endproperty
    a_false_nowrite: assert property (p_false_nowrite)
        else $error("False condition wrote.");

    property p_true_write;
        @(posedge clk) disable iff (!rst_n)
        accept && isCondPair && condTrue && selLegal |=> writeBack.accWrite && writeBack.ptrWrite
            && writeBack.ptrValue == $past(pointerFile[srcPtrSel]);
    endproperty
    a_true_write: assert property (p_true_write)
        else $error("True pair transfer missing.");

    property p_greater_equal;
        @(posedge clk) disable iff (!rst_n)
        condField == 4'h1 |-> condTrue == (flagsIn.negative == flagsIn.overflow);
    endproperty
    a_greater_equal: assert property (p_greater_equal)
        else $error("Greater-equal wrong.");

    property p_equal;
        @(posedge clk) disable iff (!rst_n)
        condField == 4'hA |-> condTrue == flagsIn.zero;
    endproperty
    a_equal: assert property (p_equal)
        else $error("Equal wrong.");

    property p_normalized;
        @(posedge clk) disable iff (!rst_n)
        condField == 4'hC && !flagsIn.zero && flagsIn.extension |-> !condTrue;
    endproperty
    a_normalized: assert property (p_normalized)
        else $error("Normalized wrong.");

    property p_test_flags;
        @(posedge clk) disable iff (!rst_n)
        accept && isTest |=> !flagsOut.overflow && flagsOut.negative == $past(testAcc[55])
            && !writeBack.accWrite;
    endproperty
    a_test_flags: assert property (p_test_flags)
        else $error("Test flags wrong.");

    property p_copy_flags;
        @(posedge clk) disable iff (!rst_n)
        accept && isCopy |=> flagsOut[5:0] == $past(flagsIn[5:0]);
    endproperty
    a_copy_flags: assert property (p_copy_flags)
        else $error("Copy altered flags.");
endmodule // ctte_exec

// >>> ctte_exec_bench.sv
// Self-checking bench for the conditional transfer and accumulator test executor.
// Assumes the executor package is compiled first and drives all ports directly.
`timescale 1ns/10ps

module ctte_exec_bench;
    import ctte_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic instrValid = 1'b0;
    logic [23:0] instrWord = 24'h0;
    logic [55:0] accA = 56'h80123456789ABC;
    logic [55:0] accB = 56'h7F000000000001;
    logic [23:0] inX0 = 24'h800001;
    logic [23:0] inX1 = 24'h7FFFFF;
    logic [23:0] inY0 = 24'h123456;
    logic [23:0] inY1 = 24'hFEDCBA;
    logic [15:0] ptrRegs [8];
    ctte_flags_type flagsIn = 8'h00;
    logic moveLimited = 1'b0;
    logic moveScaling = 1'b0;
    logic [3:0] moveExtraCycles = 4'h0;
    logic busy, done, moveEnable, flagsWrite, fw, me1;
    ctte_write_type writeBack, wb;
    ctte_flags_type flagsOut, fo;
    int cyc;
    int miscompares = 0;
    int n_compared = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Free-running 200 MHz clock.
    always #2.5 clk = ~clk;

    ctte_exec i_ctte_exec (
        .clk(clk), .rst_n(rst_n), .instrValid(instrValid), .instrWord(instrWord),
        .accA(accA), .accB(accB), .inX0(inX0), .inX1(inX1), .inY0(inY0), .inY1(inY1),
        .pointerFile(ptrRegs), .flagsIn(flagsIn), .moveLimited(moveLimited),
        .moveScaling(moveScaling), .moveExtraCycles(moveExtraCycles), .busy(busy),
        .done(done), .moveEnable(moveEnable), .writeBack(writeBack),
        .flagsWrite(flagsWrite), .flagsOut(flagsOut)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then stops.
    task automatic finish_test;
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Compares one value and reports a mismatch.
    task automatic chk(input string what, input logic [55:0] exp, input logic [55:0] got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Places an input register in the accumulator's middle, sign extended.
    function automatic logic [55:0] ext(input logic [23:0] v);
        return {{8{v[23]}}, v, 24'h0};
    endfunction

    // Works out a condition code from the flags.
    function automatic logic cond_ok(input logic [3:0] c, input ctte_flags_type f);
        logic [7:0] r;
        r = {f.zero | (f.negative ^ f.overflow), f.limit, f.extension,
            f.zero | (~f.unnormalized & ~f.extension), f.negative, f.zero,
            f.negative ^ f.overflow, f.carry};
        return c[3] ? r[c[2:0]] : ~r[c[2:0]];
    endfunction

    // Issues one instruction, waits for done and captures the results.
    task automatic run(input logic [23:0] w, input logic [3:0] extra);
        int n;
        n = 0;
        instrWord = w;
        moveExtraCycles = extra;
        instrValid = 1'b1;
        @(posedge clk);
        #1;
        instrValid = 1'b0;
        me1 = moveEnable;
        cyc = 1;
        while (done !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            #1;
            cyc++;
            n++;
        end
        if (n == 40)
        begin
            miscompares++;
            $display("unexpected done: expected 1, seen 0");
            finish_test();
        end
        wb = writeBack;
        fw = flagsWrite;
        fo = flagsOut;
        @(posedge clk);
        #1;
        chk("busy after done", 1'b0, busy);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Every condition code against every flag pattern, single form, X0 into A.
    task automatic cond_table;
        logic ok;
        for (int c = 0; c < 16; c++)
            for (int f = 0; f < 256; f++)
            begin
                flagsIn = f[7:0];
                ok = cond_ok(c[3:0], flagsIn);
                run({8'h02, c[3:0], 5'h00, 4'h8, 3'h0}, 4'h0);
                chk("cond write", ok, wb.accWrite);
                if (ok)
                    chk("cond value", ext(inX0), wb.accValue);
                chk("cond flags write", 1'b0, fw);
                chk("cond ptr write", 1'b0, wb.ptrWrite);
                chk("cond cycles", 1, cyc);
            end
    endtask

    // Paired form over all pointer numbers, equal condition true then false.
    task automatic pair_form;
        logic [2:0] d;
        for (int i = 0; i < 16; i++)
        begin
            d = ~i[2:0];
            flagsIn = i[3] ? 8'h00 : 8'h04;
            run({8'h03, 4'hA, 1'b0, i[2:0], 1'b0, 4'h1, d}, 4'h0);
            chk("pair ptr write", !i[3], wb.ptrWrite);
            chk("pair acc write", !i[3], wb.accWrite);
            chk("pair cycles", 1, cyc);
            if (!i[3])
            begin
                chk("pair ptr dest", d, wb.ptrDest);
                chk("pair ptr value", ptrRegs[i[2:0]], wb.ptrValue);
                chk("pair acc value", accA, wb.accValue);
            end
        end
    endtask

    // Every legal selector and the refused ones, condition always true.
    task automatic selectors;
        logic [55:0] exp;
        logic legal;
        flagsIn = 8'h00;
        for (int s = 0; s < 16; s++)
        begin
            legal = s < 2 || s > 7;
            exp = s[3] ? ext(s[1] ? (s[2] ? inY1 : inY0) : (s[2] ? inX1 : inX0))
                : (s[0] ? accA : accB);
            run({8'h02, 4'h0, 5'h00, s[3:0], 3'h0}, 4'h0);
            chk("sel write", legal, wb.accWrite);
            if (legal)
            begin
                chk("sel dest", s[0], wb.accDest);
                chk("sel value", exp, wb.accValue);
            end
        end
    endtask

    // Register copy with growing move overhead; move limiting and scaling set sticky flags.
    task automatic copy_timing;
        ctte_flags_type e [4] = '{8'h25, 8'h64, 8'hA7, 8'hE6};
        for (int k = 0; k < 4; k++)
        begin
            flagsIn = 8'h25 ^ k[7:0];
            moveLimited = k[0];
            moveScaling = k[1];
            run({16'h4C00, k[0] ? 8'h09 : 8'h41}, 4'(k * 5));
            chk("copy cycles", 1 + k * 5, cyc);
            chk("copy move enable", 1'b1, me1);
            chk("copy write", 1'b1, wb.accWrite);
            chk("copy value", k[0] ? accA : ext(inX0), wb.accValue);
            chk("copy flags write", 1'b1, fw);
            chk("copy flags", e[k], fo);
        end
    endtask

    // Accumulator test on zero, extended, negative unnormalized and negative normalized values.
    task automatic acc_test;
        logic [55:0] v [4] = '{56'h0, 56'h01020304000000, 56'hFFC00000000000,
            56'hFF800000000000};
        ctte_flags_type e [4] = '{8'hD4, 8'hF0, 8'hD8, 8'hC8};
        flagsIn = 8'hFF;
        for (int k = 0; k < 4; k++)
        begin
            if (k[0])
                accB = v[k];
            else
                accA = v[k];
            run({16'h0000, 4'h0, k[0], 3'b011}, 4'h2);
            chk("test write", 1'b0, wb.accWrite);
            chk("test cycles", 3, cyc);
            chk("test flags write", 1'b1, fw);
            chk("test flags", e[k], fo);
            chk("test move enable", 1'b1, me1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Reset, then every scenario in turn.
    initial
    begin
        for (int i = 0; i < 8; i++)
            ptrRegs[i] = 16'hA5C0 ^ 16'(i * 273);
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk("reset busy", 1'b0, busy);
        chk("reset done", 1'b0, done);
        chk("reset acc write", 1'b0, writeBack.accWrite);
        cond_table();
        pair_form();
        selectors();
        copy_timing();
        acc_test();
        finish_test();
    end
endmodule // ctte_exec_bench
